//--- common/ofc_pkg.sv
// Constants and carrier types of the output fault float control block.
// Assumes a 32-bit APB master and one system clock.
package ofc_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [15:0] OFC_CTRL_INDEX = 16'hFF69;
  localparam logic [31:0] OFC_CTRL_ADDR  = {14'h0000, OFC_CTRL_INDEX, 2'h0};
  localparam logic [7:0]  OFC_CTRL_RESET = 8'h00;

  // --------------------------------------------------------------
  // Field positions of output_float_ctrl
  // --------------------------------------------------------------
  localparam int OFC_BIT_ENABLE  = 7;
  localparam int OFC_BIT_GATE    = 6;
  localparam int OFC_BIT_FALL    = 5;
  localparam int OFC_BIT_RISE    = 4;
  localparam int OFC_BIT_TRIGGER = 3;
  localparam int OFC_BIT_RELEASE = 2;
  localparam int OFC_BIT_STATUS  = 0;

  localparam int OFC_NUM_PINS    = 6;
  localparam int OFC_SYNC_STAGES = 2;

  // --------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    OFC_EDGE_NONE,
    OFC_EDGE_RISE,
    OFC_EDGE_FALL,
    OFC_EDGE_BAD
  } ofc_edge_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ofc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ofc_apb_rsp_t;

  typedef struct packed {
    logic enable;
    logic gate_mode;
    logic fall_sel;
    logic rise_sel;
    logic status;
  } ofc_ctrl_t;

endpackage : ofc_pkg

//--- src/ofc_fault_sync.sv
// Two-stage synchroniser for the fault input, plus a delayed copy.
// Assumes the fault input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ofc_fault_sync
  import ofc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic fault_input_pin,
  output var  logic fault_level,
  output var  logic fault_level_d
);

  logic [OFC_SYNC_STAGES-1:0] sync;
  logic [OFC_SYNC_STAGES-1:0] next_sync;
  logic                       next_level_d;

  always_comb begin
    next_sync    = {sync[OFC_SYNC_STAGES-2:0], fault_input_pin};
    next_level_d = sync[OFC_SYNC_STAGES-1];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync          <= '0;
      fault_level_d <= 1'b0;
    end else begin
      sync          <= next_sync;
      fault_level_d <= next_level_d;
    end
  end

  assign fault_level = sync[OFC_SYNC_STAGES-1];

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sync_delay_a: assert property (
    @(posedge clk) disable iff (!resetn)
    $past(resetn, 2) |-> fault_level == $past(fault_input_pin, 2))
    else $error("fault level not two cycles behind pin");

endmodule : ofc_fault_sync
`default_nettype wire

//--- src/ofc_pin_gate.sv
// Output buffers of the six inverter timer pins with float control.
// Assumes timer outputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ofc_pin_gate
  import ofc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [OFC_NUM_PINS-1:0] timer_out,
  input  wire logic                    float_pins,
  output var  logic [OFC_NUM_PINS-1:0] pin_out,
  output var  logic [OFC_NUM_PINS-1:0] pin_oe
);

  logic [OFC_NUM_PINS-1:0] next_out;
  logic [OFC_NUM_PINS-1:0] next_oe;

  always_comb begin
    for (int i = 0; i < OFC_NUM_PINS; i++) begin
      next_out[i] = float_pins ? 1'b0 : timer_out[i];
      next_oe[i]  = ~float_pins;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

  pins_float_a: assert property (
    @(posedge clk) disable iff (!resetn)
    float_pins |=> pin_oe == '0)
    else $error("pins still driven while floated");

endmodule : ofc_pin_gate
`default_nettype wire

//--- src/ofc_top.sv
// Output fault float control: APB register, fault detection, pin float.
// Assumes an APB master on clk and six timer outputs to be gated.
`timescale 1ns/1ps
`default_nettype none

module ofc_top
  import ofc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire ofc_apb_req_t            apb_req,
  output var  ofc_apb_rsp_t            apb_rsp,
  input  wire logic                    fault_input_pin,
  input  wire logic [OFC_NUM_PINS-1:0] timer_out,
  output var  logic [OFC_NUM_PINS-1:0] pin_out,
  output var  logic [OFC_NUM_PINS-1:0] pin_oe,
  output var  logic                    float_active
);

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  function automatic ofc_edge_t edge_mode(input ofc_ctrl_t c);
    unique case ({c.fall_sel, c.rise_sel})
      2'b00:   edge_mode = OFC_EDGE_NONE;
      2'b01:   edge_mode = OFC_EDGE_RISE;
      2'b10:   edge_mode = OFC_EDGE_FALL;
      default: edge_mode = OFC_EDGE_BAD;
    endcase
  endfunction : edge_mode

  function automatic logic abnormal_level(input ofc_ctrl_t c,
                                          input logic lvl);
    unique case (edge_mode(c))
      OFC_EDGE_RISE: abnormal_level = lvl;
      OFC_EDGE_FALL: abnormal_level = ~lvl;
      default:       abnormal_level = 1'b0;
    endcase
  endfunction : abnormal_level

  function automatic logic valid_edge(input ofc_ctrl_t c,
                                      input logic lvl,
                                      input logic lvl_d);
    unique case (edge_mode(c))
      OFC_EDGE_RISE: valid_edge = lvl & ~lvl_d;
      OFC_EDGE_FALL: valid_edge = ~lvl & lvl_d;
      default:       valid_edge = 1'b0;
    endcase
  endfunction : valid_edge

  // --------------------------------------------------------------
  // Fault input synchroniser
  // --------------------------------------------------------------
  logic fault_level;
  logic fault_level_d;

  ofc_fault_sync u_sync (
    .clk             (clk),
    .resetn          (resetn),
    .fault_input_pin (fault_input_pin),
    .fault_level     (fault_level),
    .fault_level_d   (fault_level_d)
  );

  // --------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------
  ofc_ctrl_t    ctrl;
  ofc_ctrl_t    next_ctrl;
  ofc_apb_rsp_t next_rsp;
  logic         addr_hit;
  logic         setup;
  logic         access;
  logic         wr;
  logic [7:0]   wbyte;
  logic [7:0]   rbyte;

  always_comb begin
    addr_hit = apb_req.paddr == OFC_CTRL_ADDR;
    setup    = apb_req.psel & ~apb_req.penable;
    access   = apb_req.psel & apb_req.penable & apb_rsp.pready;
    wr       = access & apb_req.pwrite & addr_hit;
    wbyte    = apb_req.pwdata[7:0];
  end

  // --------------------------------------------------------------
  // Fault and command qualification
  // --------------------------------------------------------------
  logic fault_abn;
  logic fault_edge;
  logic trig_req;
  logic rel_req;
  logic trig_ok;
  logic rel_ok;
  logic set_status;

  always_comb begin
    fault_abn  = abnormal_level(ctrl, fault_level);
    fault_edge = ctrl.enable
               & valid_edge(ctrl, fault_level, fault_level_d);
    trig_req   = wr & wbyte[OFC_BIT_TRIGGER];
    rel_req    = wr & wbyte[OFC_BIT_RELEASE];
    trig_ok    = trig_req & ctrl.enable & ~fault_abn;
    rel_ok     = rel_req & ~(ctrl.gate_mode & fault_abn);
    set_status = fault_edge | trig_ok;
  end

  // --------------------------------------------------------------
  // Control register next state
  // --------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    if (wr) begin
      // Status bit is not writable; command bits are not stored
      next_ctrl.enable    = wbyte[OFC_BIT_ENABLE];
      next_ctrl.gate_mode = wbyte[OFC_BIT_GATE];
      next_ctrl.fall_sel  = wbyte[OFC_BIT_FALL];
      next_ctrl.rise_sel  = wbyte[OFC_BIT_RISE];
    end
    // Hardware set wins over a release in the same cycle
    if (set_status) begin
      next_ctrl.status = 1'b1;
    end else if (rel_ok) begin
      next_ctrl.status = 1'b0;
    end
    if (!next_ctrl.enable) begin
      next_ctrl.status = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= ofc_ctrl_t'(5'h00);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // --------------------------------------------------------------
  // Read data and response
  // --------------------------------------------------------------
  always_comb begin
    rbyte                 = OFC_CTRL_RESET;
    rbyte[OFC_BIT_ENABLE] = ctrl.enable;
    rbyte[OFC_BIT_GATE]   = ctrl.gate_mode;
    rbyte[OFC_BIT_FALL]   = ctrl.fall_sel;
    rbyte[OFC_BIT_RISE]   = ctrl.rise_sel;
    rbyte[OFC_BIT_STATUS] = ctrl.status;
  end

  always_comb begin
    next_rsp.pready  = setup;
    next_rsp.pslverr = setup & ~addr_hit;
    next_rsp.prdata  = 32'h0000_0000;
    if (setup && addr_hit && !apb_req.pwrite) begin
      next_rsp.prdata = {24'h00_0000, rbyte};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      apb_rsp      <= '0;
      float_active <= 1'b0;
    end else begin
      apb_rsp      <= next_rsp;
      float_active <= next_ctrl.status;
    end
  end

  // --------------------------------------------------------------
  // Output buffers
  // --------------------------------------------------------------
  logic float_pins;

  always_comb begin
    float_pins = ctrl.enable & ctrl.status;
  end

  ofc_pin_gate u_pins (
    .clk        (clk),
    .resetn     (resetn),
    .timer_out  (timer_out),
    .float_pins (float_pins),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe)
  );

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_armed_edge;
    fault_edge && !(wr && !wbyte[OFC_BIT_ENABLE]);
  endsequence

  sequence s_good_trigger;
    wr && wbyte[OFC_BIT_TRIGGER] && wbyte[OFC_BIT_ENABLE]
       && ctrl.enable && !fault_abn;
  endsequence

  sequence s_good_release;
    wr && wbyte[OFC_BIT_RELEASE] && !wbyte[OFC_BIT_TRIGGER]
       && !fault_edge && !(ctrl.gate_mode && fault_abn);
  endsequence

  reset_value_a: assert property (
    $rose(resetn) |-> ctrl == ofc_ctrl_t'(5'h00))
    else $error("control not zero after reset");

  read_fixed_a: assert property (
    apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h00_0000
      && apb_rsp.prdata[OFC_BIT_TRIGGER] == 1'b0
      && apb_rsp.prdata[OFC_BIT_RELEASE] == 1'b0
      && apb_rsp.prdata[1] == 1'b0)
    else $error("fixed read bits not zero");

  status_nowrite_a: assert property (
    (wr && !ctrl.status && !wbyte[OFC_BIT_TRIGGER] && !fault_edge)
      |=> !ctrl.status)
    else $error("status set by a plain write");

  disabled_clear_a: assert property (
    !ctrl.enable |-> !ctrl.status && !float_active)
    else $error("status set while disabled");

  disabled_drive_a: assert property (
    (resetn && !ctrl.enable) ##1 !ctrl.enable |-> pin_oe == '1)
    else $error("pins floated while disabled");

  no_edge_a: assert property (
    (edge_mode(ctrl) == OFC_EDGE_NONE && !ctrl.status && !wr)
      |=> !ctrl.status)
    else $error("status set with no edge selected");

  fault_float_a: assert property (
    s_armed_edge |=> ctrl.status ##1 pin_oe == '0)
    else $error("fault edge did not float pins");

  trig_set_a: assert property (
    s_good_trigger |=> ctrl.status && float_active)
    else $error("trigger did not set status");

  trig_abn_a: assert property (
    (wr && wbyte[OFC_BIT_TRIGGER] && fault_abn && !ctrl.status
       && !fault_edge) |=> !ctrl.status)
    else $error("trigger taken at abnormal level");

  trig_off_a: assert property (
    (wr && wbyte[OFC_BIT_TRIGGER] && !ctrl.enable && !fault_edge)
      |=> !ctrl.status)
    else $error("trigger taken while disabled");

  release_a: assert property (
    s_good_release |=> !ctrl.status ##1 pin_oe == '1 || !ctrl.enable)
    else $error("release did not restore drive");

  release_gate_a: assert property (
    (wr && wbyte[OFC_BIT_RELEASE] && wbyte[OFC_BIT_ENABLE]
       && ctrl.gate_mode && fault_abn && ctrl.status) |=> ctrl.status)
    else $error("release taken at abnormal level");

  rewrite_a: assert property (
    (wr && wbyte == rbyte && !set_status) |=> ctrl == $past(ctrl))
    else $error("rewrite of same value changed state");

  apb_answer_a: assert property (
    setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("APB answer not one cycle after setup");

  apb_refuse_a: assert property (
    (setup && !addr_hit) |=> apb_rsp.pslverr
      && apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

  cfg_hold_a: assert property (
    (access && apb_req.pwrite && !addr_hit)
      |=> {ctrl.enable, ctrl.gate_mode, ctrl.fall_sel, ctrl.rise_sel}
        == $past({ctrl.enable, ctrl.gate_mode, ctrl.fall_sel,
                  ctrl.rise_sel}))
    else $error("unmapped write changed control");

  read_layout_a: assert property (
    (setup && addr_hit && !apb_req.pwrite) |=> apb_rsp.prdata[7:0] ==
      {$past(ctrl.enable), $past(ctrl.gate_mode), $past(ctrl.fall_sel),
       $past(ctrl.rise_sel), 3'h0, $past(ctrl.status)})
    else $error("read data does not match control fields");

  release_open_a: assert property (
    (wr && wbyte[OFC_BIT_RELEASE] && !wbyte[OFC_BIT_TRIGGER]
       && !ctrl.gate_mode && !fault_edge) |=> !ctrl.status)
    else $error("ungated release refused");

  bad_mode_a: assert property (
    (edge_mode(ctrl) == OFC_EDGE_BAD && !ctrl.status && !wr)
      |=> !ctrl.status)
    else $error("status set with banned edge select");

  trig_float_a: assert property (
    s_good_trigger |=> ctrl.status ##1 pin_oe == '0)
    else $error("trigger did not float pins");

  rise_detect_a: assert property (
    (ctrl.enable && edge_mode(ctrl) == OFC_EDGE_RISE && fault_level
       && !fault_level_d && !(wr && !wbyte[OFC_BIT_ENABLE]))
      |=> ctrl.status && float_active)
    else $error("rising fault edge missed");

  fall_detect_a: assert property (
    (ctrl.enable && edge_mode(ctrl) == OFC_EDGE_FALL && !fault_level
       && fault_level_d && !(wr && !wbyte[OFC_BIT_ENABLE]))
      |=> ctrl.status && float_active)
    else $error("falling fault edge missed");

  pins_drive_a: assert property (
    (resetn && !float_pins)
      |=> pin_oe == '1 && pin_out == $past(timer_out))
    else $error("pins not driven with timer values");

endmodule : ofc_top
`default_nettype wire

//--- tb/ofc_fault_src.sv
// Model of the external motor fault detector driving the fault pin.
// Assumes the bench sets want and lag just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ofc_fault_src (
  input  wire logic       clk,
  input  wire logic       want,
  input  wire logic [3:0] lag,
  output var  logic       fault_pin
);
  logic [3:0] cnt;

  initial begin
    fault_pin = 1'b1;
    cnt       = 4'h0;
  end

  // Pin follows want on the lag+1th rising edge after it changes: prompt or slow detector
  always @(posedge clk) begin
    if (want == fault_pin) begin
      cnt <= 4'h0;
    end else if (cnt >= lag) begin
      fault_pin <= want;
      cnt       <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : ofc_fault_src
`default_nettype wire

//--- tb/output_fault_float_control_bench.sv
// Self-checking bench of the output fault float control block.
// Assumes ofc_top with one APB register and the fault source model.
`timescale 1ns/1ps
`default_nettype none
module output_fault_float_control_bench
  import ofc_pkg::*;
;
  logic                    clk;
  logic                    resetn;
  ofc_apb_req_t            apb_req;
  ofc_apb_rsp_t            apb_rsp;
  logic                    fault_pin;
  logic                    want;
  logic [3:0]              lag;
  logic [OFC_NUM_PINS-1:0] timer_out;
  logic [OFC_NUM_PINS-1:0] pin_out;
  logic [OFC_NUM_PINS-1:0] pin_oe;
  logic                    float_active;
  logic [7:0]              rd;
  logic                    err;
  int                      n_errors;
  int                      checks;
  int                      cyc;

  ofc_top dut (
    .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .fault_input_pin(fault_pin), .timer_out(timer_out),
    .pin_out(pin_out), .pin_oe(pin_oe), .float_active(float_active)
  );

  ofc_fault_src fault_src (
    .clk(clk), .want(want), .lag(lag), .fault_pin(fault_pin)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] addr,
                     input logic [7:0] wd);
    int n;
    @(posedge clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= addr;
    apb_req.pwdata  <= {24'h000000, wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1);
    check("pready wait", 8'h01, n[7:0]);
    rd  = apb_rsp.prdata[7:0];
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  // Write the register, then read it back
  task automatic step(input logic [7:0] d, input logic [7:0] exp);
    apb(1'b1, OFC_CTRL_ADDR, d);
    apb(1'b0, OFC_CTRL_ADDR, 8'h00);
    check("output_float_ctrl", exp, rd);
  endtask : step

  task automatic pins(input logic fl);
    repeat (3) @(posedge clk);
    check("pin_oe", fl ? 8'h00 : 8'h3F, {2'b00, pin_oe});
    check("pin_out", fl ? 8'h00 : {2'b00, timer_out}, {2'b00, pin_out});
    check("float_active", {7'h00, fl}, {7'h00, float_active});
  endtask : pins

  task automatic flt(input logic lvl);
    want <= lvl;
    repeat (16) @(posedge clk);
  endtask : flt

  // ------------------------------------------------------------
  // Clock, timeout and tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 5000) begin
        n_errors++;
        end_of_test();
      end
    end
  end

  initial begin
    resetn = 1'b0;
    apb_req = '0;
    timer_out = 6'h2D;
    want = 1'b1;
    lag = 4'h0;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, OFC_CTRL_ADDR, 8'h00);
    check("output_float_ctrl", 8'h00, rd);
    pins(1'b0);
    apb(1'b1, OFC_CTRL_ADDR + 32'h4, 8'hFF);
    check("pslverr", 8'h01, {7'h00, err});
    $display("test reset done");
    step(8'h61, 8'h60);
    step(8'h68, 8'h60);
    pins(1'b0);
    step(8'hE0, 8'hE0);
    $display("test layout done");
    lag <= 4'h5;
    flt(1'b0);
    step(8'hE0, 8'hE1);
    pins(1'b1);
    step(8'hE4, 8'hE1);
    pins(1'b1);
    flt(1'b1);
    step(8'hE4, 8'hE0);
    pins(1'b0);
    $display("test gated release done");
    lag <= 4'h0;
    timer_out <= 6'h12;
    step(8'h60, 8'h60);
    step(8'h20, 8'h20);
    step(8'hA0, 8'hA0);
    flt(1'b0);
    step(8'hA0, 8'hA1);
    step(8'hA4, 8'hA0);
    step(8'hA8, 8'hA0);
    flt(1'b1);
    step(8'hA0, 8'hA0);
    step(8'hA8, 8'hA1);
    pins(1'b1);
    step(8'hA1, 8'hA1);
    step(8'h21, 8'h20);
    pins(1'b0);
    $display("test falling edge done");
    step(8'h00, 8'h00);
    step(8'h80, 8'h80);
    flt(1'b0);
    flt(1'b1);
    step(8'h80, 8'h80);
    step(8'h88, 8'h81);
    step(8'h84, 8'h80);
    step(8'h00, 8'h00);
    step(8'h10, 8'h10);
    step(8'h90, 8'h90);
    step(8'h98, 8'h90);
    flt(1'b0);
    step(8'h90, 8'h90);
    flt(1'b1);
    step(8'h90, 8'h91);
    step(8'h94, 8'h90);
    step(8'h10, 8'h10);
    step(8'h30, 8'h30);
    step(8'hB0, 8'hB0);
    flt(1'b0);
    flt(1'b1);
    step(8'hB0, 8'hB0);
    $display("test edge select done");
    end_of_test();
  end
endmodule : output_fault_float_control_bench
`default_nettype wire
